// File: logic/dosc_top.sv
// Dual oscillator clock switch with APB control registers.
//
// How it works
// R1 - CPU clock comes from slow or fast oscillator per clock select bit.
// R2 - Slow oscillator is 32.768 kHz crystal or 60 kHz RC by option.
// R3 - Fast oscillator also feeds the timer and clock output pin.
// R4 - Fast oscillator enable bit starts or stops the fast oscillator.
// R5 - Core voltage select gives 1.35 V for slow, 2.25 V for fast.
// R6 - Software raises core voltage, waits 2.5 ms, then enables fast oscillator.
// R7 - Software waits 5 ms after enable before selecting the fast clock.
// R8 - Returning: select slow, disable fast, lower voltage, then regulator mode.
// R9 - Supply 0.9 V to 1.4 V: regulator only in booster-supply mode.
// R10 - Supply 1.4 V to 2.3 V with slow clock: regulator in normal mode.
// R11 - Supply 2.3 V to 3.6 V: normal mode for either clock.
// R12 - Software picks booster-supply mode when the supply detector sees a drop.
// R13 - Instruction cycle lasts two source periods: 61, 33 or 0.5 us.
// R14 - Fast select ignored while core voltage low and fast oscillator off.
// R15 - RC slow option fixes core voltage high regardless of select bit.
// R16 - Reset clears clock select, oscillator enable and voltage select.
// R17 - Regulator supply select 1 gives booster supply, 0 gives main supply.
// R18 - Source change happens only while both oscillator clocks are low.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module dosc_top (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Oscillators and mask option.
  input wire logic SLOW_OSC_CLK,
  input wire logic FAST_OSC_CLK,
  input wire logic RC_SLOW_OPTION,
  // Clock and power outputs.
  output logic CPU_CLK,
  output logic FAST_OSC_RUN,
  output logic FAST_PERIPH_CLK,
  output logic CORE_VOLTAGE_HIGH,
  output logic BOOSTER_SUPPLY_MODE,
  output logic INSTR_CYCLE_TICK
);

  dosc_pkg::dosc_state_type s_q;
  dosc_pkg::dosc_state_type s_d;
  logic access;
  logic wr_now;
  logic new_core_volt;
  logic new_fast_en;
  logic both_low;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus, control bits, source switch and instruction tick.
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'h0;
    s_d.pslverr = 1'h0;
    s_d.tick = 1'h0;
    access = PSEL && PENABLE;
    wr_now = access && s_q.pready && PWRITE;
    new_core_volt = PWDATA[dosc_pkg::CORE_VOLT_SEL_BIT];
    new_fast_en = PWDATA[dosc_pkg::FAST_OSC_EN_BIT];
    both_low = !s_q.ls && !s_q.hs;
    // The strap is caught on the first edge after reset release.
    if (!s_q.strap_done) begin
      s_d.rc_opt = RC_SLOW_OPTION; // R2
      s_d.strap_done = 1'h1;
    end
    // Sample the oscillators; a disabled fast oscillator stays low.
    s_d.ls = SLOW_OSC_CLK;
    s_d.hs = FAST_OSC_CLK && s_q.fast_osc_en; // R4
    // One wait state, then the answer; read data is loaded with it.
    if (access && !s_q.pready) begin
      s_d.pready = 1'h1;
      s_d.prdata = dosc_pkg::ZERO_WORD;
      case (PADDR)
        dosc_pkg::CTRL_ADDR: begin
          s_d.prdata[dosc_pkg::CORE_VOLT_SEL_BIT] = s_q.core_volt_sel;
          s_d.prdata[dosc_pkg::FAST_OSC_EN_BIT] = s_q.fast_osc_en;
          s_d.prdata[dosc_pkg::CLKSEL_BIT] = s_q.clksel;
        end
        dosc_pkg::SUPPLY_ADDR: begin
          s_d.prdata[dosc_pkg::REG_SUPPLY_SEL_BIT] = s_q.reg_supply_sel;
        end
        dosc_pkg::STATUS_ADDR: begin
          s_d.prdata[dosc_pkg::ST_FAST_BIT] = (s_q.mux == dosc_pkg::MUX_FAST);
          s_d.prdata[dosc_pkg::ST_RC_BIT] = s_q.rc_opt;
          s_d.prdata[dosc_pkg::ST_CORE_BIT] = s_q.core_high;
        end
        default: begin
          s_d.pslverr = 1'h1;
        end
      endcase
    end
    // Writes take effect at the edge where the master sees the answer.
    if (wr_now) begin
      case (PADDR)
        dosc_pkg::CTRL_ADDR: begin
          s_d.core_volt_sel = new_core_volt; // R5
          s_d.fast_osc_en = new_fast_en; // R4
          // A fast request with low voltage and the oscillator off is dropped.
          // The RC option pins the core voltage high, so there the request stands.
          s_d.clksel = PWDATA[dosc_pkg::CLKSEL_BIT] &&
              (new_core_volt || new_fast_en || s_q.rc_opt); // R1 R14
        end
        dosc_pkg::SUPPLY_ADDR: begin
          s_d.reg_supply_sel = PWDATA[dosc_pkg::REG_SUPPLY_SEL_BIT]; // R17
        end
        default: begin
          s_d.reg_supply_sel = s_q.reg_supply_sel;
        end
      endcase
    end
    // The old source is followed until both clocks are low, then the new one.
    case (s_q.mux)
      dosc_pkg::MUX_SLOW: begin
        s_d.cpu_clk = s_q.ls;
        if (s_q.clksel) begin
          s_d.mux = dosc_pkg::MUX_TO_FAST;
        end
      end
      dosc_pkg::MUX_TO_FAST: begin
        s_d.cpu_clk = s_q.ls;
        if (!s_q.clksel) begin
          s_d.mux = dosc_pkg::MUX_SLOW;
        end else if (both_low) begin
          s_d.mux = dosc_pkg::MUX_FAST; // R18
        end
      end
      dosc_pkg::MUX_FAST: begin
        s_d.cpu_clk = s_q.hs; // R1
        if (!s_q.clksel) begin
          s_d.mux = dosc_pkg::MUX_TO_SLOW;
        end
      end
      dosc_pkg::MUX_TO_SLOW: begin
        s_d.cpu_clk = s_q.hs;
        if (both_low) begin
          s_d.mux = dosc_pkg::MUX_SLOW; // R18
        end
      end
      default: begin
        s_d.mux = dosc_pkg::MUX_SLOW;
      end
    endcase
    // An instruction cycle ends on every second CPU clock rising edge.
    s_d.cpu_clk_prev = s_q.cpu_clk;
    if (s_q.cpu_clk && !s_q.cpu_clk_prev) begin
      s_d.phase = !s_q.phase;
      s_d.tick = s_q.phase; // R13
    end
    // Core voltage is high when selected or when the RC slow option is fitted.
    s_d.core_high = s_d.core_volt_sel || s_d.rc_opt; // R5 R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset gives slow clock, oscillator off and low voltage.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0; // R16
      s_q.mux <= dosc_pkg::MUX_SLOW;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign PREADY = s_q.pready;
  assign PRDATA = s_q.prdata;
  assign PSLVERR = s_q.pslverr;
  assign CPU_CLK = s_q.cpu_clk; // R1 R2
  assign FAST_OSC_RUN = s_q.fast_osc_en; // R4
  assign FAST_PERIPH_CLK = s_q.hs; // R3
  assign BOOSTER_SUPPLY_MODE = s_q.reg_supply_sel; // R17
  assign INSTR_CYCLE_TICK = s_q.tick; // R13
  assign CORE_VOLTAGE_HIGH = s_q.core_high; // R5 R15

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence ctrl_write_s;
    PSEL && PENABLE && PWRITE && PREADY && PADDR == dosc_pkg::CTRL_ADDR;
  endsequence

  sequence into_fast_s;
    s_q.mux == dosc_pkg::MUX_TO_FAST ##1 s_q.mux == dosc_pkg::MUX_FAST;
  endsequence

  a_answer_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("APB answer not after one wait state");
  a_fast_refused: assert property (ctrl_write_s and (!PWDATA[0] && !PWDATA[2] // R14
      && !s_q.rc_opt) |=> !s_q.clksel)
    else $error("fast select taken with low voltage and oscillator off");
  a_fast_taken: assert property (ctrl_write_s and (PWDATA[3] && PWDATA[0]) // R1
      |=> s_q.clksel ##1 s_q.mux != dosc_pkg::MUX_SLOW)
    else $error("fast select not taken");
  a_switch_safe: assert property (into_fast_s |-> $past(!s_q.ls && !s_q.hs)) // R18
    else $error("source switched while a clock was high");
  a_slow_low: assert property (s_q.mux == dosc_pkg::MUX_TO_SLOW ##1 s_q.mux == // R18
      dosc_pkg::MUX_SLOW |-> !CPU_CLK)
    else $error("cpu clock high right after return to slow");
  a_core_volt: assert property (ctrl_write_s |=> ##1 CORE_VOLTAGE_HIGH == // R5 R15
      ($past(PWDATA[0], 2) || s_q.rc_opt))
    else $error("core voltage does not follow select bit");
  a_osc_gate: assert property (!FAST_OSC_RUN |=> !FAST_PERIPH_CLK) // R4
    else $error("fast clock running while disabled");
  a_booster_sel: assert property (PSEL && PENABLE && PWRITE && PREADY && // R17
      PADDR == dosc_pkg::SUPPLY_ADDR |=> BOOSTER_SUPPLY_MODE == $past(PWDATA[2]))
    else $error("regulator supply select not stored");
  a_tick_pair: assert property (INSTR_CYCLE_TICK |=> !INSTR_CYCLE_TICK) // R13
    else $error("instruction tick longer than one cycle");
  a_reset_clear: assert property ($rose(RSTN) |-> !s_q.clksel && !s_q.fast_osc_en && // R16
      !s_q.core_volt_sel)
    else $error("control bits not cleared by reset");

endmodule // dosc_top

// File: pkg/dosc_pkg.sv
// Package of constants and types for the dual oscillator clock switch.
package dosc_pkg;
  // Register byte addresses on the APB.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] SUPPLY_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  // Control register field positions.
  localparam int CORE_VOLT_SEL_BIT = 0;
  localparam int FAST_OSC_EN_BIT = 2;
  localparam int CLKSEL_BIT = 3;
  // Supply register field position.
  localparam int REG_SUPPLY_SEL_BIT = 2;
  // Status register field positions.
  localparam int ST_FAST_BIT = 0;
  localparam int ST_RC_BIT = 1;
  localparam int ST_CORE_BIT = 2;
  // Reset values: slow clock, fast oscillator off, low core voltage, normal regulator.
  localparam logic RST_BIT = 1'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0;
  // Nominal oscillator figures in kHz, for reference only; the bench does not use them.
  localparam real SLOW_XTAL_KHZ = 32.768;
  localparam real SLOW_RC_KHZ = 60.0;
  localparam real FAST_RC_KHZ = 1800.0;
  localparam real FAST_CER_MAX_KHZ = 4000.0;
  // Instruction cycle times in microseconds for each source.
  localparam real ICYC_XTAL_US = 61.0;
  localparam real ICYC_RC_US = 33.0;
  localparam real ICYC_FAST_US = 0.5;
  // Source clock periods that make one instruction cycle.
  localparam int PERIODS_PER_ICYC = 2;

  // States of the glitch-free source multiplexer.
  typedef enum {MUX_SLOW, MUX_TO_FAST, MUX_FAST, MUX_TO_SLOW} dosc_mux_type;

  // Whole state of the block.
  typedef struct packed {
    logic core_volt_sel;
    logic fast_osc_en;
    logic clksel;
    logic reg_supply_sel;
    logic rc_opt;
    logic strap_done;
    logic ls;
    logic hs;
    dosc_mux_type mux;
    logic cpu_clk;
    logic cpu_clk_prev;
    logic phase;
    logic tick;
    logic core_high;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dosc_state_type;
endpackage

// File: verification/test_dual_oscillator_clock_switch.sv
// Self-checking testbench for the dual oscillator clock switch.
`timescale 1ns/1ps
module test_dual_oscillator_clock_switch;
  logic clk_sys, rstn, psel, penable, pwrite, slow_osc, fast_osc, rc_opt;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdata;
  logic rerr, pready, pslverr, cpu_clk, fast_run, periph_clk, core_high, booster, tick;
  logic [31:0] prdata;
  logic [3:0] div = 4'h0;
  int num_errors = 0;
  int samples_checked = 0;
  int r, t, p;

  dosc_top dosc_top_i (
    .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .SLOW_OSC_CLK(slow_osc), .FAST_OSC_CLK(fast_osc), .RC_SLOW_OPTION(rc_opt),
    .CPU_CLK(cpu_clk), .FAST_OSC_RUN(fast_run), .FAST_PERIPH_CLK(periph_clk),
    .CORE_VOLTAGE_HIGH(core_high), .BOOSTER_SUPPLY_MODE(booster), .INSTR_CYCLE_TICK(tick));

  // The clock runs at 40 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Slow source has a period of 16 system cycles, the fast one 4.
  always @(posedge clk_sys) begin
    div <= div + 4'h1;
    slow_osc <= div[3];
    fast_osc <= div[1];
  end

  // Compares a seen value with the expected one and counts both outcomes.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the edge where pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ends when pready is sampled high; the watchdog ends a hang.
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so that outputs launched by the write have settled.
    @(posedge clk_sys);
  endtask

  // Counts rises of the CPU clock, ticks and peripheral clock over a window.
  task watch(input int cycles);
    logic c0, p0;
    r = 0;
    t = 0;
    p = 0;
    c0 = cpu_clk;
    p0 = periph_clk;
    repeat (cycles) begin
      @(posedge clk_sys);
      if (cpu_clk === 1'b1 && c0 === 1'b0) r++;
      if (periph_clk === 1'b1 && p0 === 1'b0) p++;
      if (tick === 1'b1) t++;
      c0 = cpu_clk;
      p0 = periph_clk;
    end
  endtask

  // Holds reset for five cycles with the given oscillator option strap.
  task do_reset(input logic rc);
    rstn <= 1'b0;
    rc_opt <= rc;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    test_done;
  end

  // Main sequence of tests.
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rc_opt = 1'b0;
    do_reset(1'b0);
    apb(1'b0, dosc_pkg::CTRL_ADDR, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, dosc_pkg::SUPPLY_ADDR, 32'h0);
    check(rdata, 32'h0);
    check({fast_run, core_high, booster}, 32'h0);
    $display("test reset values done");
    apb(1'b1, 8'h0C, 32'hF);
    apb(1'b0, 8'h0C, 32'h0);
    check(rerr, 1'b1);
    check(rdata, 32'h0);
    apb(1'b1, dosc_pkg::STATUS_ADDR, 32'hF);
    apb(1'b0, dosc_pkg::CTRL_ADDR, 32'h0);
    check(rdata, 32'h0);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h8);
    apb(1'b0, dosc_pkg::CTRL_ADDR, 32'h0);
    check(rdata, 32'h0);
    apb(1'b0, dosc_pkg::STATUS_ADDR, 32'h0);
    check(rdata, 32'h0);
    watch(64);
    check(32'(r >= 3 && r < 6), 32'h1);
    $display("test refused accesses done");
    apb(1'b1, dosc_pkg::SUPPLY_ADDR, 32'h4);
    check(booster, 1'b1);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h1);
    check(core_high, 1'b1);
    watch(16);
    check(p, 0);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h5);
    check(fast_run, 1'b1);
    watch(64);
    check(32'(p > 8), 32'h1);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'hD);
    repeat (20) begin
      apb(1'b0, dosc_pkg::STATUS_ADDR, 32'h0);
      if (rdata[0] === 1'b1) break;
    end
    check(rdata, 32'h5);
    watch(64);
    check(32'(r > 10), 32'h1);
    check(32'(t >= r / 2 - 1 && t <= r / 2 + 1), 32'h1);
    $display("test switch to fast done");
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h5);
    watch(40);
    apb(1'b0, dosc_pkg::STATUS_ADDR, 32'h0);
    check(rdata, 32'h4);
    watch(64);
    check(32'(r >= 3 && r < 6), 32'h1);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h1);
    check(fast_run, 1'b0);
    watch(32);
    check(p, 0);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h0);
    check(core_high, 1'b0);
    apb(1'b1, dosc_pkg::SUPPLY_ADDR, 32'h0);
    check(booster, 1'b0);
    $display("test return to slow done");
    do_reset(1'b1);
    apb(1'b0, dosc_pkg::STATUS_ADDR, 32'h0);
    check(rdata, 32'h6);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h0);
    check(core_high, 1'b1);
    apb(1'b1, dosc_pkg::CTRL_ADDR, 32'h8);
    apb(1'b0, dosc_pkg::CTRL_ADDR, 32'h0);
    check(rdata, 32'h8);
    $display("test rc option done");
    test_done;
  end
endmodule // test_dual_oscillator_clock_switch
